// *** logic/scm_defines.svh ***
// timing counts, bit positions and reset values for the serial module
`ifndef SCM_DEFINES_SVH
`define SCM_DEFINES_SVH
`define SCM_CLK_NS 20
`define SCM_BITCLK_NS 160
`define SCM_BITCLK_CYC (`SCM_BITCLK_NS / `SCM_CLK_NS)
`define SCM_LOW_WINDOW_CYC (3 * `SCM_BITCLK_CYC + 1)
`define SCM_FAULT_BIT 4'h6
`define SCM_LAST_BIT 4'h7
`define SCM_START_HOLD_CYC 8'h08
`define SCM_UART_BIT_CYC 8'h10
`define SCM_UART_HALF_CYC 8'h08
`define SCM_UART_STOP_IDX 4'h8
`define SCM_BYTE_RESET 8'h00
`endif

// *** logic/scm_pkg.sv ***
// types shared by the serial module
package scm_pkg;
  typedef enum logic [3:0] {
    MM_IDLE = 4'b0001,
    MM_WAIT = 4'b0010,
    MM_START = 4'b0100,
    MM_ACTIVE = 4'b1000
  } scm_master_type;

  typedef enum logic [1:0] {
    UR_IDLE = 2'b01,
    UR_SHIFT = 2'b10
  } scm_uart_type;

  typedef struct packed {
    logic [7:0] data;
    logic framing_error;
  } scm_uart_byte_type;
endpackage : scm_pkg

// *** logic/scm_serial.sv ***
// serial module: i2c receive window, multi-master start wait, uart receive after soft reset
`timescale 1ns/1ns
`include "scm_defines.svh"

module scm_serial (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire logic uart_rxd,
  input wire logic soft_reset_bit,
  input wire logic sync_mode_bit,
  input wire logic multi_master_enable,
  input wire logic transmitter_select,
  input wire logic start_request_set,
  input wire logic rx_buf_read,
  input wire logic tx_buf_write,
  input wire logic [7:0] tx_buf_data,
  output logic clock_low_flag,
  output logic [7:0] i2c_receive_buffer,
  output logic rx_pending_flag,
  output logic rx_abort_flag,
  output logic bus_busy,
  output logic start_request_bit,
  output logic tx_pending_flag,
  output logic [7:0] tx_holding_buffer,
  output logic tx_discard,
  output logic activity_flag,
  output scm_pkg::scm_uart_byte_type uart_byte,
  output logic uart_byte_valid
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] rxd_sync;
  logic scl_prev;
  logic sda_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      rxd_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      rxd_sync <= {rxd_sync[0], uart_rxd};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl & ~scl_prev;
  assign scl_fall = ~scl & scl_prev;
  assign start_seen = scl & scl_prev & ~sda & sda_prev;
  assign stop_seen = scl & scl_prev & sda & ~sda_prev;

  // ----------------------------------------
  // bus state and clock-low timer
  // ----------------------------------------
  logic [7:0] low_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_busy <= 1'b0;
      low_cnt <= 8'h00;
    end else begin
      if (soft_reset_bit || stop_seen) begin
        bus_busy <= 1'b0;
      end else if (start_seen) begin
        bus_busy <= 1'b1;
      end
      if (scl) begin
        low_cnt <= 8'h00;
      end else if (low_cnt != 8'hFF) begin
        low_cnt <= low_cnt + 8'h01;
      end
    end
  end

  assign clock_low_flag = ~scl;

  // ----------------------------------------
  // i2c receiver, double buffered
  // ----------------------------------------
  logic [7:0] rx_shift;
  logic [3:0] rx_bit;
  logic low_window_done;
  logic fault_read;
  assign low_window_done = low_cnt >= 8'(`SCM_LOW_WINDOW_CYC);
  // a pending byte read during the seventh bit of the next byte, before scl has been low for SCM_LOW_WINDOW_CYC cycles, aborts it
  assign fault_read = rx_buf_read && rx_pending_flag && (rx_bit == `SCM_FAULT_BIT)
    && !low_window_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shift <= `SCM_BYTE_RESET;
      rx_bit <= 4'h0;
      i2c_receive_buffer <= `SCM_BYTE_RESET;
      rx_pending_flag <= 1'b0;
      rx_abort_flag <= 1'b0;
    end else if (soft_reset_bit) begin
      rx_bit <= 4'h0;
      rx_pending_flag <= 1'b0;
      rx_abort_flag <= 1'b0;
    end else begin
      if (start_seen || stop_seen || fault_read) begin
        rx_bit <= 4'h0;
      end else if (scl_rise && !transmitter_select) begin
        rx_shift <= {rx_shift[6:0], sda};
        rx_bit <= (rx_bit == `SCM_LAST_BIT) ? 4'h0 : rx_bit + 4'h1;
      end
      if (fault_read) begin
        rx_abort_flag <= 1'b1;
      end else if (start_seen) begin
        rx_abort_flag <= 1'b0;
      end
      if (scl_rise && !transmitter_select && rx_bit == `SCM_LAST_BIT && !fault_read) begin
        i2c_receive_buffer <= {rx_shift[6:0], sda};
        rx_pending_flag <= 1'b1;
      end else if (rx_buf_read) begin
        rx_pending_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // multi-master start sequencing
  // ----------------------------------------
  scm_pkg::scm_master_type mm_state;
  logic [7:0] start_cnt;
  logic tx_ok;
  assign tx_ok = tx_buf_write && mm_state == scm_pkg::MM_ACTIVE;
  assign tx_discard = tx_buf_write && mm_state == scm_pkg::MM_WAIT;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mm_state <= scm_pkg::MM_IDLE;
      start_cnt <= 8'h00;
    end else if (soft_reset_bit) begin
      mm_state <= scm_pkg::MM_IDLE;
      start_cnt <= 8'h00;
    end else begin
      unique case (mm_state)
        scm_pkg::MM_IDLE: begin
          if (start_request_bit && transmitter_select) begin
            if (multi_master_enable && bus_busy) begin
              mm_state <= scm_pkg::MM_WAIT;
            end else begin
              mm_state <= scm_pkg::MM_START;
            end
          end
          start_cnt <= 8'h00;
        end
        scm_pkg::MM_WAIT: begin
          if (!bus_busy) begin
            mm_state <= scm_pkg::MM_START;
          end
        end
        scm_pkg::MM_START: begin
          start_cnt <= start_cnt + 8'h01;
          if (start_cnt == `SCM_START_HOLD_CYC) begin
            mm_state <= scm_pkg::MM_ACTIVE;
          end
        end
        scm_pkg::MM_ACTIVE: begin
          if (!transmitter_select) begin
            mm_state <= scm_pkg::MM_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_request_bit <= 1'b0;
      tx_pending_flag <= 1'b0;
      tx_holding_buffer <= `SCM_BYTE_RESET;
    end else if (soft_reset_bit) begin
      start_request_bit <= 1'b0;
      tx_pending_flag <= 1'b0;
    end else begin
      if (start_request_set) begin
        start_request_bit <= 1'b1;
      end else if (mm_state == scm_pkg::MM_START && start_cnt == `SCM_START_HOLD_CYC) begin
        start_request_bit <= 1'b0;
      end
      if (mm_state == scm_pkg::MM_WAIT && scl_fall) begin
        tx_pending_flag <= 1'b1;
      end else if (mm_state == scm_pkg::MM_START && start_cnt == `SCM_START_HOLD_CYC) begin
        tx_pending_flag <= 1'b1;
      end else if (tx_buf_write) begin
        tx_pending_flag <= 1'b0;
      end
      if (tx_ok) begin
        tx_holding_buffer <= tx_buf_data;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = mm_state == scm_pkg::MM_START;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;

  // ----------------------------------------
  // uart receiver
  // ----------------------------------------
  scm_pkg::scm_uart_type ur_state;
  logic [7:0] ur_cnt;
  logic [3:0] ur_idx;
  logic [7:0] ur_shift;
  logic stale_frame;
  logic rxd;
  assign rxd = rxd_sync[1];
  assign activity_flag = ur_state == scm_pkg::UR_SHIFT;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stale_frame <= 1'b0;
    end else if (soft_reset_bit && activity_flag) begin
      stale_frame <= 1'b1;
    end else if (soft_reset_bit && sync_mode_bit) begin
      stale_frame <= 1'b0;
    end else if (uart_byte_valid) begin
      stale_frame <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ur_state <= scm_pkg::UR_IDLE;
      ur_cnt <= 8'h00;
      ur_idx <= 4'h0;
      ur_shift <= `SCM_BYTE_RESET;
      uart_byte <= '0;
      uart_byte_valid <= 1'b0;
    end else if (soft_reset_bit || sync_mode_bit) begin
      ur_state <= scm_pkg::UR_IDLE;
      ur_cnt <= 8'h00;
      ur_idx <= 4'h0;
      uart_byte_valid <= 1'b0;
    end else begin
      uart_byte_valid <= 1'b0;
      unique case (ur_state)
        scm_pkg::UR_IDLE: begin
          ur_idx <= 4'h0;
          if (!rxd) begin
            ur_state <= scm_pkg::UR_SHIFT;
            ur_cnt <= `SCM_UART_HALF_CYC + `SCM_UART_BIT_CYC;
          end
        end
        scm_pkg::UR_SHIFT: begin
          if (ur_cnt != 8'h00) begin
            ur_cnt <= ur_cnt - 8'h01;
          end else if (ur_idx == `SCM_UART_STOP_IDX) begin
            ur_state <= scm_pkg::UR_IDLE;
            uart_byte.data <= ur_shift;
            uart_byte.framing_error <= !rxd || stale_frame;
            uart_byte_valid <= 1'b1;
          end else begin
            ur_shift <= {rxd, ur_shift[7:1]};
            ur_idx <= ur_idx + 4'h1;
            ur_cnt <= `SCM_UART_BIT_CYC - 8'h01;
          end
        end
      endcase
    end
  end
endmodule : scm_serial

// *** test/scm_serial_asserts.sv ***
// assertion checker for the serial module
`timescale 1ns/1ns
module scm_serial_asserts (
  input logic clk,
  input logic rst,
  input logic sda_oe,
  input logic clock_low_flag,
  input logic rx_buf_read,
  input logic rx_pending_flag,
  input logic rx_abort_flag,
  input logic bus_busy,
  input logic start_request_bit,
  input logic tx_pending_flag,
  input logic [7:0] tx_holding_buffer,
  input logic tx_buf_write,
  input logic activity_flag,
  input logic soft_reset_bit,
  input logic sync_mode_bit,
  input logic multi_master_enable,
  input logic transmitter_select,
  input scm_pkg::scm_uart_byte_type uart_byte,
  input logic uart_byte_valid
);
  logic stale;
  logic [7:0] lc;
  wire wt = start_request_bit && multi_master_enable && transmitter_select && bus_busy && !sda_oe && !soft_reset_bit;
  always_ff @(posedge clk or posedge rst)
    if (rst) stale <= 1'h0;
    else stale <= soft_reset_bit ? activity_flag | stale & !sync_mode_bit : stale & !uart_byte_valid;
  always_ff @(posedge clk or posedge rst)
    if (rst) lc <= 8'h00;
    else lc <= clock_low_flag ? lc + {7'h00, lc != 8'hFF} : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wait; wt |=> !sda_oe; endproperty
  a_wait: assert property (p_wait) else $error("start on busy bus");
  property p_pend; wt [*3] ##0 $rose(clock_low_flag) |-> ##[0:3] tx_pending_flag; endproperty
  a_pend: assert property (p_pend) else $error("tx pending not set");
  property p_drop; tx_buf_write && start_request_bit && !soft_reset_bit |=> $stable(tx_holding_buffer); endproperty
  a_drop: assert property (p_drop) else $error("early write stored");
  property p_frame; uart_byte_valid && stale |-> uart_byte.framing_error; endproperty
  a_frame: assert property (p_frame) else $error("framing error missing");
  property p_safe; rx_buf_read && lc > 8'h1A |=> !$rose(rx_abort_flag); endproperty
  a_safe: assert property (p_safe) else $error("safe read aborted");
  property p_abort; $rose(rx_abort_flag) |-> $past(rx_buf_read) && $past(rx_pending_flag); endproperty
  a_abort: assert property (p_abort) else $error("abort without read");
  c_rx: cover property ($rose(rx_pending_flag));
  c_abort: cover property ($rose(rx_abort_flag));
  c_frame: cover property (uart_byte_valid && uart_byte.framing_error);
endmodule : scm_serial_asserts
bind scm_serial scm_serial_asserts u_chk (.clk, .rst, .sda_oe, .clock_low_flag, .rx_buf_read, .rx_pending_flag,
  .rx_abort_flag, .bus_busy, .start_request_bit, .tx_pending_flag, .tx_holding_buffer, .tx_buf_write,
  .activity_flag, .soft_reset_bit, .sync_mode_bit, .multi_master_enable, .transmitter_select, .uart_byte,
  .uart_byte_valid);

// *** test/scm_line_model.sv ***
// line-side model: i2c bus peer and uart sender
`timescale 1ns/1ns
module scm_line_model (
  output logic scl,
  output logic sda,
  output logic rxd,
  output logic [3:0] bit_idx
);
  initial begin
    scl = 1'h1;
    sda = 1'h1;
    rxd = 1'h1;
    bit_idx = 4'h0;
  end
  task automatic i2c_start;
    sda = 1'h0;
    #160;
  endtask : i2c_start
  task automatic i2c_stop;
    scl = 1'h0;
    sda = 1'h0;
    #80 scl = 1'h1;
    #80 sda = 1'h1;
    #320;
  endtask : i2c_stop
  // msb first, low phase of the seventh bit stretched by lo7
  task automatic i2c_byte(input logic [7:0] d, input int lo7);
    for (int i = 0; i < 8; i++) begin
      scl = 1'h0;
      bit_idx = 4'(i);
      sda = d[7 - i];
      #((i == 6) ? lo7 : 80) scl = 1'h1;
      #80;
    end
  endtask : i2c_byte
  task automatic uart_send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      #320;
    end
  endtask : uart_send
endmodule : scm_line_model

// *** test/tb_scm_serial.sv ***
// testbench for the serial module
`timescale 1ns/1ns
module tb_scm_serial;
  logic clk = 1'h0, rst = 1'h1, soft_reset_bit = 1'h0, sync_mode_bit = 1'h0, multi_master_enable = 1'h0;
  logic transmitter_select = 1'h0, start_request_set = 1'h0, rx_buf_read = 1'h0, tx_buf_write = 1'h0;
  logic scl, sda, rxd, sda_oe, clock_low_flag, rx_pending_flag, rx_abort_flag, bus_busy, start_request_bit;
  logic tx_pending_flag, tx_discard, activity_flag, uart_byte_valid, scl_out, scl_oe, sda_out;
  logic [7:0] tx_buf_data = 8'h00, i2c_receive_buffer, tx_holding_buffer;
  logic [3:0] bit_idx;
  scm_pkg::scm_uart_byte_type uart_byte;
  int failures = 0, n_compared = 0;
  always #10 clk = ~clk;
  scm_line_model u_line (.scl, .sda, .rxd, .bit_idx);
  scm_serial uut (.clk, .rst, .scl_in(scl), .sda_in(sda & ~sda_oe), .scl_out, .scl_oe, .sda_out, .sda_oe,
    .uart_rxd(rxd), .soft_reset_bit, .sync_mode_bit, .multi_master_enable, .transmitter_select, .start_request_set,
    .rx_buf_read, .tx_buf_write, .tx_buf_data, .clock_low_flag, .i2c_receive_buffer, .rx_pending_flag,
    .rx_abort_flag, .bus_busy, .start_request_bit, .tx_pending_flag, .tx_holding_buffer, .tx_discard,
    .activity_flag, .uart_byte, .uart_byte_valid);
  task automatic check(input string s, input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : check
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic rd;
    @(posedge clk) rx_buf_read <= 1'h1;
    @(posedge clk) rx_buf_read <= 1'h0;
  endtask : rd
  task automatic wr(input logic [7:0] d, input logic disc);
    @(posedge clk) tx_buf_write <= 1'h1;
    tx_buf_data <= d;
    @(negedge clk) check("tx_discard", tx_discard, disc);
    @(posedge clk) tx_buf_write <= 1'h0;
    @(negedge clk) check("tx_hold", tx_holding_buffer, disc ? 8'h00 : d);
  endtask : wr
  task automatic rx_safe;
    u_line.i2c_start;
    u_line.i2c_byte(8'h3C, 80);
    @(negedge clk) check("rx_pend", rx_pending_flag, 8'h01);
    check("rx_data", i2c_receive_buffer, 8'h3C);
    fork
      u_line.i2c_byte(8'hC3, 800);
      begin
        wait (bit_idx == 4'h6 && clock_low_flag === 1'h1);
        repeat (30) @(posedge clk);
        rd;
        @(negedge clk) check("rx_pend", rx_pending_flag, 8'h00);
        check("rx_hold", i2c_receive_buffer, 8'h3C);
      end
    join
    repeat (4) @(negedge clk);
    check("rx_data", i2c_receive_buffer, 8'hC3);
    check("rx_abort", rx_abort_flag, 8'h00);
    rd;
    @(negedge clk) check("rx_pend", rx_pending_flag, 8'h00);
    u_line.i2c_stop;
  endtask : rx_safe
  task automatic rx_fault;
    u_line.i2c_start;
    u_line.i2c_byte(8'h5A, 80);
    fork
      u_line.i2c_byte(8'h96, 80);
      wait (bit_idx == 4'h6) rd;
    join
    @(negedge clk) check("rx_abort", rx_abort_flag, 8'h01);
    u_line.i2c_stop;
  endtask : rx_fault
  task automatic uart_reset(input logic fix);
    fork
      u_line.uart_send(8'h11);
      begin
        #1300 @(negedge clk) check("activity", activity_flag, 8'h01);
        @(posedge clk) soft_reset_bit <= 1'h1;
      end
    join
    if (fix) begin
      @(posedge clk) sync_mode_bit <= 1'h1;
      @(posedge clk) sync_mode_bit <= 1'h0;
    end
    @(posedge clk) soft_reset_bit <= 1'h0;
    fork
      u_line.uart_send(8'hC6);
      begin
        @(posedge uart_byte_valid);
        @(negedge clk) check("uart_valid", uart_byte_valid, 8'h01);
        @(negedge clk) check("uart_valid", uart_byte_valid, 8'h00);
      end
    join
    @(negedge clk) check("uart_frame", uart_byte.framing_error, fix ? 8'h00 : 8'h01);
    if (fix) check("uart_data", uart_byte.data, 8'hC6);
  endtask : uart_reset
  task automatic uart_idle_reset;
    wait (activity_flag === 1'h0);
    @(posedge clk) soft_reset_bit <= 1'h1;
    @(posedge clk) soft_reset_bit <= 1'h0;
    u_line.uart_send(8'h3A);
    @(negedge clk) check("uart_frame", uart_byte.framing_error, 8'h00);
    check("uart_data", uart_byte.data, 8'h3A);
  endtask : uart_idle_reset
  task automatic mm_wait;
    @(posedge clk) multi_master_enable <= 1'h1;
    transmitter_select <= 1'h1;
    u_line.i2c_start;
    @(negedge clk) check("bus_busy", bus_busy, 8'h01);
    @(posedge clk) start_request_set <= 1'h1;
    @(posedge clk) start_request_set <= 1'h0;
    u_line.i2c_byte(8'h00, 80);
    @(negedge clk) check("sda_oe", sda_oe, 8'h00);
    check("start_req", start_request_bit, 8'h01);
    check("tx_pend", tx_pending_flag, 8'h01);
    wr(8'h77, 1'h1);
    fork
      u_line.i2c_stop;
      begin
        wait (sda_oe === 1'h1);
        @(negedge clk) check("sda_out", sda_out, 8'h00);
        check("scl_oe", scl_oe, 8'h00);
        check("scl_out", scl_out, 8'h00);
      end
    join
    repeat (100) @(negedge clk) if (start_request_bit === 1'h0) break;
    check("start_req", start_request_bit, 8'h00);
    wr(8'hA5, 1'h0);
  endtask : mm_wait
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rx_safe;
    rx_fault;
    uart_reset(1'h0);
    uart_idle_reset;
    uart_reset(1'h1);
    mm_wait;
    end_of_test;
  end
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
endmodule : tb_scm_serial
